// *** jfps_top.sv ***
// Behaviour
// - Flash timing tick derived from test clock edges, which are detected by sampling on the system clock.
// - Addresses are 17-bit flash-word addresses, absolute bits 4 to 20.
// - All sectors protected after reset; only unprotected sectors erase or write.
// - No programming accepted until initialization has completed.
// - Protect/unprotect: 1100, header, then five-bit selector 00000 or 00001.
// - Erase start pattern, clock kept running, then done and close patterns.
module jfps_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic debug_select_pin,
  output logic tdo,
  output logic tdo_oe,
  output logic flash_tick,
  output logic init_done,
  output logic erase_busy,
  output logic [jfps_pkg::N_SECT-1:0] prot_flags,
  output logic op_valid,
  output logic [2:0] op_code,
  output logic [jfps_pkg::ADDR_W-1:0] op_addr,
  output logic [jfps_pkg::N_SECT-1:0] op_mask,
  output logic [jfps_pkg::WORD_W-1:0] op_data,
  output logic [jfps_pkg::RATE_W-1:0] flash_clock_rate_value,
  output logic op_denied
);

  typedef struct packed {
    logic [4:0] pin_m;
    logic [4:0] pin_s;
    logic [jfps_pkg::DR_W-1:0] dr;
    logic [7:0] cnt;
    logic [jfps_pkg::IR_W-1:0] ir_sh;
    logic flash_mode;
    jfps_pkg::jfps_seq_t st;
    logic [jfps_pkg::N_SECT-1:0] prot;
    logic protect_sel;
    logic [jfps_pkg::N_SECT-1:0] ers_mask;
    logic [jfps_pkg::ADDR_W-1:0] addr;
    logic [jfps_pkg::RATE_W-1:0] rate;
    logic op_valid;
    logic [2:0] op_code;
    logic [jfps_pkg::ADDR_W-1:0] op_addr;
    logic [jfps_pkg::N_SECT-1:0] op_mask;
    logic [jfps_pkg::WORD_W-1:0] op_data;
    logic op_denied;
    logic init_done;
    logic erase_busy;
    logic flash_tick;
    logic tdo;
    logic tdo_oe;
  } jfps_top_state_t;

  jfps_top_state_t r_reg;
  jfps_top_state_t r_next;
  logic rst_m_n;
  logic rst_s_n;
  jfps_tap_if tp ();

  // ==========================================================
  // Reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_n <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m_n <= 1'b1;
      rst_s_n <= rst_m_n;
    end
  end

  jfps_tap u_tap (
    .clock(clock),
    .rst_s_n(rst_s_n),
    .tp(tp)
  );

  assign tp.tck_s = r_reg.pin_s[0];
  assign tp.tms_s = r_reg.pin_s[1];
  assign tp.trst_s_n = r_reg.pin_s[3];

  // ==========================================================
  // Pattern helpers
  function automatic logic pat_hit(input logic [jfps_pkg::DR_W-1:0] d,
    input logic [7:0] n, input logic [7:0] len, input logic [21:0] pat);
    logic [jfps_pkg::DR_W-1:0] sh;
    sh = d >> (jfps_pkg::DR_LEN - len);
    pat_hit = (n == len) && (sh[21:0] == pat);
  endfunction

  function automatic logic pfx_hit(input logic [jfps_pkg::DR_W-1:0] d,
    input logic [7:0] n, input logic [7:0] len, input logic [3:0] pfx);
    pfx_hit = (n == len) && (d[jfps_pkg::DR_W-1 -: 4] == pfx);
  endfunction

  function automatic logic [jfps_pkg::ADDR_W-1:0] field_addr(
    input logic [jfps_pkg::DR_W-1:0] d);
    logic [jfps_pkg::ADDR_W-1:0] a;
    a = '0;
    for (int i = 0; i < jfps_pkg::ADDR_W; i++) begin
      a[i] = d[jfps_pkg::FIELD_TOP - i];
    end
    field_addr = a;
  endfunction

  function automatic logic [3:0] sect_of(input logic [16:0] a);
    sect_of = a[jfps_pkg::ADDR_W-1:jfps_pkg::SECT_LSB];
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [jfps_pkg::DR_W-1:0] d;
    logic [7:0] n;
    logic [jfps_pkg::ADDR_W-1:0] fa;
    d = r_reg.dr;
    n = r_reg.cnt;
    fa = field_addr(r_reg.dr);
    r_next = r_reg;
    r_next.pin_m = {debug_select_pin, trst_n, tdi, tms, tck};
    r_next.pin_s = r_reg.pin_m;
    r_next.op_valid = 1'b0;
    r_next.flash_tick = tp.rise & r_reg.flash_mode;
    if (tp.in_reset) begin
      r_next.flash_mode = 1'b0;
    end
    if (tp.cap_ir && tp.rise) begin
      r_next.ir_sh = jfps_pkg::IR_CAPTURE;
    end
    if (tp.shift_ir && tp.rise) begin
      r_next.ir_sh = {r_reg.pin_s[2], r_reg.ir_sh[jfps_pkg::IR_W-1:1]};
    end
    if (tp.upd_ir && tp.fall) begin
      r_next.flash_mode = (r_reg.ir_sh == jfps_pkg::IR_FLASH)
        && r_reg.pin_s[4];
    end
    if (tp.cap_dr && tp.rise) begin
      r_next.cnt = 8'h00;
    end
    if (tp.shift_dr && tp.rise) begin
      r_next.dr = {r_reg.pin_s[2], r_reg.dr[jfps_pkg::DR_W-1:1]};
      if (r_reg.cnt != 8'hff) begin
        r_next.cnt = r_reg.cnt + 8'h01;
      end
    end
    if (tp.fall) begin
      r_next.tdo = tp.shift_ir ? r_reg.ir_sh[0] : r_reg.dr[0];
      r_next.tdo_oe = tp.shift_ir | tp.shift_dr;
    end
    if (tp.upd_dr && tp.fall && r_reg.flash_mode) begin
      case (r_reg.st)
        jfps_pkg::SQ_IDLE: begin
          if (n == jfps_pkg::LEN_INIT && d[159 -: 8] == jfps_pkg::PAT_INIT_HEAD) begin
            r_next.st = jfps_pkg::SQ_INIT;
          end
        end
        jfps_pkg::SQ_INIT: begin
          if (n == jfps_pkg::LEN_INIT && d[159 -: 8] == jfps_pkg::PAT_INIT_HEAD) begin
            r_next.init_done = 1'b1;
            r_next.st = jfps_pkg::SQ_READY;
          end
        end
        jfps_pkg::SQ_READY: begin
          if (pat_hit(d, n, jfps_pkg::LEN_4, jfps_pkg::PAT_SEL)) begin
            r_next.st = jfps_pkg::SQ_SEL;
          end else if (pat_hit(d, n, jfps_pkg::LEN_4, jfps_pkg::PAT_WR)) begin
            r_next.st = jfps_pkg::SQ_WHDR;
          end
        end
        jfps_pkg::SQ_SEL: begin
          r_next.ers_mask = '0;
          if (pat_hit(d, n, jfps_pkg::LEN_21, jfps_pkg::PAT_PROT_HDR)) begin
            r_next.st = jfps_pkg::SQ_PMODE;
          end else if (pat_hit(d, n, jfps_pkg::LEN_22, jfps_pkg::PAT_ERS_HDR)) begin
            r_next.st = jfps_pkg::SQ_ELIST;
          end else begin
            r_next.st = jfps_pkg::SQ_READY;
          end
        end
        jfps_pkg::SQ_PMODE: begin
          if (pat_hit(d, n, jfps_pkg::LEN_5, jfps_pkg::PAT_UNPROT)) begin
            r_next.protect_sel = 1'b0;
            r_next.st = jfps_pkg::SQ_PLIST;
          end else if (pat_hit(d, n, jfps_pkg::LEN_5, jfps_pkg::PAT_PROT)) begin
            r_next.protect_sel = 1'b1;
            r_next.st = jfps_pkg::SQ_PLIST;
          end else begin
            r_next.st = jfps_pkg::SQ_READY;
          end
        end
        jfps_pkg::SQ_PLIST: begin
          if (pat_hit(d, n, jfps_pkg::LEN_4, jfps_pkg::PAT_SECT)) begin
            r_next.st = jfps_pkg::SQ_PADDR;
          end else if (pat_hit(d, n, jfps_pkg::LEN_7, jfps_pkg::PAT_PROT_END)) begin
            r_next.st = jfps_pkg::SQ_PCL1;
          end
        end
        jfps_pkg::SQ_PADDR: begin
          if (pfx_hit(d, n, jfps_pkg::LEN_21, jfps_pkg::PFX_MORE)) begin
            r_next.prot[sect_of(fa)] = r_reg.protect_sel;
            r_next.op_valid = 1'b1;
            r_next.op_code = r_reg.protect_sel ? jfps_pkg::OP_PROT
              : jfps_pkg::OP_UNPROT;
            r_next.op_addr = fa;
            r_next.op_denied = 1'b0;
            r_next.st = jfps_pkg::SQ_PLIST;
          end
        end
        jfps_pkg::SQ_PCL1: begin
          if (pat_hit(d, n, jfps_pkg::LEN_4, jfps_pkg::PAT_SEL)) begin
            r_next.st = jfps_pkg::SQ_PCL2;
          end
        end
        jfps_pkg::SQ_PCL2: begin
          if (pat_hit(d, n, jfps_pkg::LEN_19, jfps_pkg::PAT_PROT_CLOSE)) begin
            r_next.st = jfps_pkg::SQ_READY;
          end
        end
        jfps_pkg::SQ_ELIST: begin
          if (pfx_hit(d, n, jfps_pkg::LEN_21, jfps_pkg::PFX_MORE)) begin
            r_next.ers_mask[sect_of(fa)] = 1'b1;
          end else if (pat_hit(d, n, jfps_pkg::LEN_7, jfps_pkg::PAT_ERS_LAST)) begin
            r_next.st = jfps_pkg::SQ_ELAST;
          end
        end
        jfps_pkg::SQ_ELAST: begin
          if (pfx_hit(d, n, jfps_pkg::LEN_21, jfps_pkg::PFX_LAST)) begin
            r_next.ers_mask[sect_of(fa)] = 1'b1;
            r_next.st = jfps_pkg::SQ_ERATE;
          end
        end
        jfps_pkg::SQ_ERATE: begin
          if (n == jfps_pkg::LEN_12) begin
            for (int i = 0; i < jfps_pkg::RATE_W; i++) begin
              r_next.rate[i] = d[jfps_pkg::DR_W-1-i];
            end
            r_next.st = jfps_pkg::SQ_EARM;
          end
        end
        jfps_pkg::SQ_EARM: begin
          if (pat_hit(d, n, jfps_pkg::LEN_22, jfps_pkg::PAT_ERS_GO)) begin
            r_next.op_valid = 1'b1;
            r_next.op_code = jfps_pkg::OP_ERASE;
            r_next.op_mask = r_reg.ers_mask & ~r_reg.prot;
            r_next.op_denied = |(r_reg.ers_mask & r_reg.prot);
            r_next.erase_busy = 1'b1;
            r_next.st = jfps_pkg::SQ_ERUN;
          end
        end
        jfps_pkg::SQ_ERUN: begin
          if (pat_hit(d, n, jfps_pkg::LEN_22, jfps_pkg::PAT_ERS_DONE)) begin
            r_next.erase_busy = 1'b0;
            r_next.st = jfps_pkg::SQ_EEND;
          end
        end
        jfps_pkg::SQ_EEND: begin
          if (pat_hit(d, n, jfps_pkg::LEN_21, jfps_pkg::PAT_ERS_CLOSE)) begin
            r_next.st = jfps_pkg::SQ_READY;
          end
        end
        jfps_pkg::SQ_WHDR: begin
          if (pat_hit(d, n, jfps_pkg::LEN_22, jfps_pkg::PAT_WR_HDR)) begin
            r_next.st = jfps_pkg::SQ_WADDR;
          end
        end
        jfps_pkg::SQ_WADDR: begin
          if (pfx_hit(d, n, jfps_pkg::LEN_21, jfps_pkg::PFX_LAST)) begin
            r_next.addr = fa;
            r_next.st = jfps_pkg::SQ_WDATA;
          end
        end
        jfps_pkg::SQ_WDATA: begin
          if (pfx_hit(d, n, jfps_pkg::LEN_WORD, jfps_pkg::PFX_WORD)) begin
            for (int i = 0; i < jfps_pkg::WORD_W; i++) begin
              r_next.op_data[i] = d[jfps_pkg::FIELD_TOP-i];
            end
            r_next.op_valid = 1'b1;
            r_next.op_code = jfps_pkg::OP_WORD;
            r_next.op_addr = r_reg.addr;
            r_next.op_denied = r_reg.prot[sect_of(r_reg.addr)];
            r_next.addr = r_reg.addr + 17'h00001;
          end else if (pat_hit(d, n, jfps_pkg::LEN_4, jfps_pkg::PAT_WORD)) begin
            r_next.op_valid = 1'b1;
            r_next.op_code = jfps_pkg::OP_PAGE;
            r_next.op_addr = r_reg.addr;
            r_next.op_denied = r_reg.prot[sect_of(r_reg.addr)];
            r_next.st = jfps_pkg::SQ_WTAIL;
          end
        end
        jfps_pkg::SQ_WTAIL: begin
          if (pat_hit(d, n, jfps_pkg::LEN_21, jfps_pkg::PAT_WR_CLOSE)) begin
            r_next.st = jfps_pkg::SQ_READY;
          end
        end
        default: r_next.st = jfps_pkg::SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      r_reg <= '0;
      r_reg.st <= jfps_pkg::SQ_IDLE;
      r_reg.prot <= '1;
      r_reg.ir_sh <= jfps_pkg::IR_CAPTURE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tdo = r_reg.tdo;
  assign tdo_oe = r_reg.tdo_oe;
  assign flash_tick = r_reg.flash_tick;
  assign init_done = r_reg.init_done;
  assign erase_busy = r_reg.erase_busy;
  assign prot_flags = r_reg.prot;
  assign op_valid = r_reg.op_valid;
  assign op_code = r_reg.op_code;
  assign op_addr = r_reg.op_addr;
  assign op_mask = r_reg.op_mask;
  assign op_data = r_reg.op_data;
  assign flash_clock_rate_value = r_reg.rate;
  assign op_denied = r_reg.op_denied;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_s_n);

  tick_from_tck_a: assert property (r_reg.flash_tick |-> $past(tp.rise))
    else $error("flash tick without test clock edge");
  prot_reset_a: assert property (!r_reg.init_done |-> &r_reg.prot)
    else $error("sector unprotected before init");
  no_early_op_a: assert property (!r_reg.init_done |-> !r_reg.op_valid)
    else $error("operation before init");
  erase_guard_a: assert property (r_reg.op_valid &&
    r_reg.op_code == jfps_pkg::OP_ERASE |-> (r_reg.op_mask & r_reg.prot) == '0)
    else $error("erase of protected sector");
  prot_apply_a: assert property (r_reg.op_valid &&
    r_reg.op_code == jfps_pkg::OP_PROT |-> r_reg.prot[r_reg.op_addr[16:13]])
    else $error("protect not applied");
  erase_start_a: assert property ($rose(r_reg.erase_busy) |->
    r_reg.op_valid && r_reg.op_code == jfps_pkg::OP_ERASE)
    else $error("erase busy without erase op");
  addr_step_a: assert property (r_reg.op_valid &&
    r_reg.op_code == jfps_pkg::OP_WORD |-> r_reg.addr == r_reg.op_addr + 17'h00001)
    else $error("word address did not advance");

  init_cv: cover property ($rose(r_reg.init_done));
  erase_cv: cover property ($fell(r_reg.erase_busy));
  word_cv: cover property (r_reg.op_valid && r_reg.op_code == jfps_pkg::OP_WORD);
  unprot_cv: cover property (r_reg.op_valid && r_reg.op_code == jfps_pkg::OP_UNPROT);

endmodule

// *** jfps_pkg.sv ***
package jfps_pkg;

  // ==========================================================
  // Shift path geometry
  localparam int DR_W = 160;
  localparam logic [7:0] DR_LEN = 8'd160;
  localparam int IR_W = 6;
  localparam logic [5:0] IR_FLASH = 6'h08;
  localparam logic [5:0] IR_CAPTURE = 6'h01;
  localparam int ADDR_W = 17;
  localparam int RATE_W = 12;
  localparam int WORD_W = 128;
  localparam int N_SECT = 16;
  localparam int SECT_LSB = 13;
  localparam int FIELD_TOP = 155;

  // ==========================================================
  // Pattern lengths in bits
  localparam logic [7:0] LEN_4 = 8'd4;
  localparam logic [7:0] LEN_5 = 8'd5;
  localparam logic [7:0] LEN_7 = 8'd7;
  localparam logic [7:0] LEN_12 = 8'd12;
  localparam logic [7:0] LEN_19 = 8'd19;
  localparam logic [7:0] LEN_21 = 8'd21;
  localparam logic [7:0] LEN_22 = 8'd22;
  localparam logic [7:0] LEN_WORD = 8'd132;
  localparam logic [7:0] LEN_INIT = 8'd32;

  // ==========================================================
  // Data patterns, leftmost listed bit is the MSB
  localparam logic [7:0] PAT_INIT_HEAD = 8'ha4;
  localparam logic [21:0] PAT_SEL = 22'h00000c;
  localparam logic [21:0] PAT_PROT_HDR = 22'h103840;
  localparam logic [21:0] PAT_UNPROT = 22'h000000;
  localparam logic [21:0] PAT_PROT = 22'h000001;
  localparam logic [21:0] PAT_SECT = 22'h000004;
  localparam logic [21:0] PAT_PROT_END = 22'h000002;
  localparam logic [21:0] PAT_PROT_CLOSE = 22'h001400;
  localparam logic [21:0] PAT_ERS_HDR = 22'h205080;
  localparam logic [21:0] PAT_ERS_LAST = 22'h000022;
  localparam logic [21:0] PAT_ERS_GO = 22'h304080;
  localparam logic [21:0] PAT_ERS_DONE = 22'h305080;
  localparam logic [21:0] PAT_ERS_CLOSE = 22'h022800;
  localparam logic [21:0] PAT_WR = 22'h000008;
  localparam logic [21:0] PAT_WR_HDR = 22'h107008;
  localparam logic [21:0] PAT_WORD = 22'h000002;
  localparam logic [21:0] PAT_WR_CLOSE = 22'h005008;
  localparam logic [3:0] PFX_MORE = 4'hf;
  localparam logic [3:0] PFX_LAST = 4'h1;
  localparam logic [3:0] PFX_WORD = 4'h2;

  // ==========================================================
  // Operation codes towards the flash array
  localparam logic [2:0] OP_UNPROT = 3'h0;
  localparam logic [2:0] OP_PROT = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_WORD = 3'h3;
  localparam logic [2:0] OP_PAGE = 3'h4;

  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SDR = 16'h0004,
    TAP_CDR = 16'h0008, TAP_SHDR = 16'h0010, TAP_E1DR = 16'h0020,
    TAP_PDR = 16'h0040, TAP_E2DR = 16'h0080, TAP_UDR = 16'h0100,
    TAP_SIR = 16'h0200, TAP_CIR = 16'h0400, TAP_SHIR = 16'h0800,
    TAP_E1IR = 16'h1000, TAP_PIR = 16'h2000, TAP_E2IR = 16'h4000,
    TAP_UIR = 16'h8000
  } jfps_tap_t;

  typedef enum logic [18:0] {
    SQ_IDLE = 19'h00001, SQ_INIT = 19'h00002, SQ_READY = 19'h00004,
    SQ_SEL = 19'h00008, SQ_PMODE = 19'h00010, SQ_PLIST = 19'h00020,
    SQ_PADDR = 19'h00040, SQ_PCL1 = 19'h00080, SQ_PCL2 = 19'h00100,
    SQ_ELIST = 19'h00200, SQ_ELAST = 19'h00400, SQ_ERATE = 19'h00800,
    SQ_EARM = 19'h01000, SQ_ERUN = 19'h02000, SQ_EEND = 19'h04000,
    SQ_WHDR = 19'h08000, SQ_WADDR = 19'h10000, SQ_WDATA = 19'h20000,
    SQ_WTAIL = 19'h40000
  } jfps_seq_t;

endpackage

// *** jfps_tap_if.sv ***
interface jfps_tap_if;
  logic tck_s;
  logic tms_s;
  logic trst_s_n;
  logic rise;
  logic fall;
  logic in_reset;
  logic cap_dr;
  logic shift_dr;
  logic upd_dr;
  logic cap_ir;
  logic shift_ir;
  logic upd_ir;
  modport tap (input tck_s, tms_s, trst_s_n, output rise, fall, in_reset,
    cap_dr, shift_dr, upd_dr, cap_ir, shift_ir, upd_ir);
  modport core (output tck_s, tms_s, trst_s_n, input rise, fall, in_reset,
    cap_dr, shift_dr, upd_dr, cap_ir, shift_ir, upd_ir);
endinterface

// *** jfps_tap.sv ***
module jfps_tap (
  input wire logic clock,
  input wire logic rst_s_n,
  jfps_tap_if.tap tp
);

  typedef struct packed {
    jfps_pkg::jfps_tap_t st;
    logic tck_d;
  } jfps_tap_state_t;

  jfps_tap_state_t r_reg;
  jfps_tap_state_t r_next;
  jfps_pkg::jfps_tap_t nx;

  // ==========================================================
  // Standard test access port state machine
  always_comb begin
    case (r_reg.st)
      jfps_pkg::TAP_TLR: nx = tp.tms_s ? jfps_pkg::TAP_TLR : jfps_pkg::TAP_RTI;
      jfps_pkg::TAP_RTI: nx = tp.tms_s ? jfps_pkg::TAP_SDR : jfps_pkg::TAP_RTI;
      jfps_pkg::TAP_SDR: nx = tp.tms_s ? jfps_pkg::TAP_SIR : jfps_pkg::TAP_CDR;
      jfps_pkg::TAP_CDR: nx = tp.tms_s ? jfps_pkg::TAP_E1DR : jfps_pkg::TAP_SHDR;
      jfps_pkg::TAP_SHDR: nx = tp.tms_s ? jfps_pkg::TAP_E1DR : jfps_pkg::TAP_SHDR;
      jfps_pkg::TAP_E1DR: nx = tp.tms_s ? jfps_pkg::TAP_UDR : jfps_pkg::TAP_PDR;
      jfps_pkg::TAP_PDR: nx = tp.tms_s ? jfps_pkg::TAP_E2DR : jfps_pkg::TAP_PDR;
      jfps_pkg::TAP_E2DR: nx = tp.tms_s ? jfps_pkg::TAP_UDR : jfps_pkg::TAP_SHDR;
      jfps_pkg::TAP_UDR: nx = tp.tms_s ? jfps_pkg::TAP_SDR : jfps_pkg::TAP_RTI;
      jfps_pkg::TAP_SIR: nx = tp.tms_s ? jfps_pkg::TAP_TLR : jfps_pkg::TAP_CIR;
      jfps_pkg::TAP_CIR: nx = tp.tms_s ? jfps_pkg::TAP_E1IR : jfps_pkg::TAP_SHIR;
      jfps_pkg::TAP_SHIR: nx = tp.tms_s ? jfps_pkg::TAP_E1IR : jfps_pkg::TAP_SHIR;
      jfps_pkg::TAP_E1IR: nx = tp.tms_s ? jfps_pkg::TAP_UIR : jfps_pkg::TAP_PIR;
      jfps_pkg::TAP_PIR: nx = tp.tms_s ? jfps_pkg::TAP_E2IR : jfps_pkg::TAP_PIR;
      jfps_pkg::TAP_E2IR: nx = tp.tms_s ? jfps_pkg::TAP_UIR : jfps_pkg::TAP_SHIR;
      jfps_pkg::TAP_UIR: nx = tp.tms_s ? jfps_pkg::TAP_SDR : jfps_pkg::TAP_RTI;
      default: nx = jfps_pkg::TAP_TLR;
    endcase
    r_next = r_reg;
    r_next.tck_d = tp.tck_s;
    if (!tp.trst_s_n) begin
      r_next.st = jfps_pkg::TAP_TLR;
    end else if (tp.rise) begin
      r_next.st = nx;
    end
  end

  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      r_reg <= '{st: jfps_pkg::TAP_TLR, tck_d: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign tp.rise = tp.tck_s & ~r_reg.tck_d;
  assign tp.fall = ~tp.tck_s & r_reg.tck_d;
  assign tp.in_reset = (r_reg.st == jfps_pkg::TAP_TLR);
  assign tp.cap_dr = (r_reg.st == jfps_pkg::TAP_CDR);
  assign tp.shift_dr = (r_reg.st == jfps_pkg::TAP_SHDR);
  assign tp.upd_dr = (r_reg.st == jfps_pkg::TAP_UDR);
  assign tp.cap_ir = (r_reg.st == jfps_pkg::TAP_CIR);
  assign tp.shift_ir = (r_reg.st == jfps_pkg::TAP_SHIR);
  assign tp.upd_ir = (r_reg.st == jfps_pkg::TAP_UIR);

  // ==========================================================
  // Checks
  trst_tlr_a: assert property (@(posedge clock) disable iff (!rst_s_n)
    !tp.trst_s_n |=> r_reg.st == jfps_pkg::TAP_TLR)
    else $error("tap not in reset after trst");
  shift_exit_a: assert property (@(posedge clock) disable iff (!rst_s_n)
    tp.trst_s_n && tp.rise && tp.tms_s && r_reg.st == jfps_pkg::TAP_SHDR
    |=> r_reg.st == jfps_pkg::TAP_E1DR)
    else $error("shift dr did not exit on tms");
  upd_ir_cv: cover property (@(posedge clock) disable iff (!rst_s_n)
    r_reg.st == jfps_pkg::TAP_UIR);

endmodule

// *** jfps_prog.sv ***
// ==========================================================
// Programmer model on the test port
module jfps_prog (
  input wire logic clock,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck = 1'b0,
  output logic tms = 1'b1,
  output logic tdi = 1'b0,
  output logic trst_n = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic so = 1'b0;
  logic soe = 1'b0;
  logic all_oe = 1'b0;
  logic [159:0] seen = '0;
  // Clock stands low outside frames; unused data bits toggle
  // Output sampled just before each rise, as a tester does
  task automatic tick(input logic m, input logic d);
    @(posedge clock);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clock);
    so = tdo;
    soe = tdo_oe;
    tck <= 1'b1;
    repeat (4) @(posedge clock);
    tck <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) tick(1'b0, ~tdi);
  endtask
  task automatic start();
    trst_n <= 1'b1;
    repeat (5) tick(1'b1, ~tdi);
    idle(1);
  endtask
  task automatic scan(input logic ir, input logic [159:0] v, input int n);
    tick(1'b1, ~tdi);
    if (ir)
      tick(1'b1, ~tdi);
    idle(2);
    seen = '0;
    all_oe = 1'b1;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, v[i]);
      seen[i] = so;
      all_oe = all_oe & soe;
    end
    tick(1'b1, ~tdi);
    idle(1);
  endtask
endmodule

// *** jfps_tb.sv ***
// ==========================================================
// Bench top with expected operation model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] c; logic [16:0] a; logic [15:0] m;
    logic d; logic [127:0] w;} jfps_exp_t;
  logic clock, rst_n, tck, tms, tdi, trst_n, debug_select_pin, tdo, tdo_oe;
  logic flash_tick, init_done, erase_busy, op_valid, op_denied;
  logic [2:0] op_code;
  logic [16:0] op_addr, a;
  logic [15:0] prot_flags, op_mask, m_prot;
  logic [127:0] op_data;
  logic [11:0] flash_clock_rate_value;
  jfps_exp_t q[$];
  int miscompares = 0, total_checks = 0, ticks = 0;
  jfps_top i_jfps_top (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .debug_select_pin(debug_select_pin),
    .tdo(tdo), .tdo_oe(tdo_oe), .flash_tick(flash_tick),
    .init_done(init_done), .erase_busy(erase_busy), .op_valid(op_valid),
    .prot_flags(prot_flags), .op_code(op_code), .op_addr(op_addr),
    .op_mask(op_mask), .op_data(op_data), .op_denied(op_denied),
    .flash_clock_rate_value(flash_clock_rate_value));
  jfps_prog i_jfps_prog (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
  task automatic chk(input logic [127:0] s, input logic [127:0] e,
    input string t);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, t);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic dr(input logic [159:0] v, input int n);
    i_jfps_prog.scan(1'b0, v, n);
  endtask
  function automatic logic [159:0] fld(input logic [3:0] p,
    input logic [16:0] x);
    logic [16:0] r;
    r = {<<{x}};
    return 160'({p, r});
  endfunction
  task automatic prot(input logic p, input logic [16:0] x, input logic on);
    if (on) begin
      q.push_back('{p ? 3'h1 : 3'h0, x, 16'h0, 1'b0, 128'h0});
      m_prot[x[16:13]] = p;
    end
    dr(160'hc, 4);
    dr(160'h103840, 21);
    dr(160'(p), 5);
    dr(160'h4, 4);
    dr(fld(4'hf, x), 21);
    dr(160'h2, 7);
    dr(160'hc, 4);
    dr(160'h1400, 19);
    chk(128'(prot_flags), 128'(m_prot), "protect flags");
  endtask
  task automatic erase(input logic [16:0] x0, input logic [16:0] x1);
    jfps_exp_t x;
    x = '{3'h2, 17'h0, 16'h0, 1'b0, 128'h0};
    x.m[x0[16:13]] = !m_prot[x0[16:13]];
    x.m[x1[16:13]] = !m_prot[x1[16:13]];
    x.d = m_prot[x0[16:13]] | m_prot[x1[16:13]];
    dr(160'hc, 4);
    dr(160'h205080, 22);
    dr(fld(4'hf, x0), 21);
    dr(160'h22, 7);
    dr(fld(4'h1, x1), 21);
    dr(160'h980, 12);
    q.push_back(x);
    dr(160'h304080, 22);
    @(posedge clock);
    ticks = 0;
    i_jfps_prog.idle(10);
    @(posedge clock);
    chk(128'(ticks), 128'ha, "flash ticks");
    chk(128'(erase_busy), 128'h1, "erase busy");
    dr(160'h305080, 22);
    dr(160'h22800, 21);
    chk(128'(erase_busy), 128'h0, "erase idle");
  endtask
  task automatic wr(input logic [16:0] x, input int nw);
    logic [16:0] y;
    logic [127:0] w, rw;
    dr(160'h8, 4);
    dr(160'h107008, 22);
    dr(fld(4'h1, x), 21);
    y = x;
    for (int k = 0; k < nw; k++) begin
      w = {$urandom, $urandom, $urandom, $urandom};
      rw = {<<{w}};
      q.push_back('{3'h3, y, 16'h0, m_prot[y[16:13]], w});
      dr(160'({4'h2, rw}), 132);
      y = y + 17'h00001;
    end
    q.push_back('{3'h4, y, 16'h0, m_prot[y[16:13]], 128'h0});
    dr(160'h2, 4);
    i_jfps_prog.idle(5);
    dr(160'h8, 4);
    dr(160'h5008, 21);
  endtask
  always @(posedge clock) begin
    if (flash_tick === 1'b1)
      ticks++;
    if (op_valid === 1'b1 && q.size() == 0)
      chk(128'h1, 128'h0, "unrequested op");
    else if (op_valid === 1'b1) begin
      chk(128'(op_code), 128'(q[0].c), "op code");
      chk(128'(op_denied), 128'(q[0].d), "denial");
      if (q[0].c == 3'h2) begin
        chk(128'(op_mask), 128'(q[0].m), "erase mask");
        chk(128'(flash_clock_rate_value), 128'h19, "rate");
      end else
        chk(128'(op_addr), 128'(q[0].a), "op address");
      if (q[0].c == 3'h3)
        chk(op_data, q[0].w, "word data");
      void'(q.pop_front());
    end
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #600us;
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(32'h8fbd));
    rst_n = 1'b0;
    debug_select_pin = 1'b1;
    m_prot = 16'hffff;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chk(128'(prot_flags), 128'hffff, "reset protect");
    i_jfps_prog.start();
    i_jfps_prog.scan(1'b1, 160'h8, 6);
    chk(128'(i_jfps_prog.seen[5:0]), 128'(jfps_pkg::IR_CAPTURE),
      "ir capture");
    chk(128'(i_jfps_prog.all_oe), 128'h1, "tdo enable");
    chk(128'(tdo_oe), 128'h0, "tdo released");
    prot(1'b0, 17'h6000, 1'b0);
    dr(160'ha4000000, 32);
    i_jfps_prog.idle(20);
    dr(160'ha4000000, 32);
    chk(128'(init_done), 128'h1, "init done");
    a = {4'h3, 13'($urandom)};
    prot(1'b0, a, 1'b1);
    erase(a, {4'h9, 13'($urandom)});
    wr({4'h9, 13'($urandom)}, 1);
    wr(a, 2);
    prot(1'b1, a, 1'b1);
    debug_select_pin <= 1'b0;
    i_jfps_prog.scan(1'b1, 160'h8, 6);
    prot(1'b0, a, 1'b0);
    chk(128'(q.size()), 128'h0, "pending ops");
    conclude();
  end
endmodule
